// ### core/clear_exec_regs.svh
// register map, field positions, reset values and timing counts
`ifndef CLEAR_EXEC_REGS_SVH
`define CLEAR_EXEC_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CX_OFS_INSTR 12'h000
`define CX_OFS_STATUS 12'h004
`define CX_OFS_ACC 12'h008
`define CX_OFS_COUNT 12'h00C

// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define CX_ST_ZERO 0
`define CX_ST_PD 3
`define CX_ST_TO 4
`define CX_ST_BUSY 8
`define CX_ST_CLASS_LO 12

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CX_RST_ACC 8'h00
`define CX_RST_ZERO 1'b0
`define CX_RST_TO 1'b1
`define CX_RST_PD 1'b1
`define CX_RST_INSTR 14'h0000

// ----------------------------------------------------------------
// opcode encodings
// ----------------------------------------------------------------
`define CX_PFX_FILE_CLR 7'h03
`define CX_PFX_ACC_CLR 7'h02
`define CX_OPC_WDT_CLR 14'h0064
`define CX_CLEAR_VALUE 8'h00

// ----------------------------------------------------------------
// timing: each internal phase lasts this many pclk cycles
// ----------------------------------------------------------------
`define CX_PHASE_NS 100
`define CX_PCLK_NS 10
`define CX_PHASE_CYC (`CX_PHASE_NS / `CX_PCLK_NS)

`endif

// ### core/clear_exec_pkg.sv
// types shared by the clear-instruction execute logic
package clear_exec_pkg;

    // instruction classes after decode
    typedef enum logic [1:0] {
        OP_OTHER,
        OP_FILE_CLR,
        OP_ACC_CLR,
        OP_WDT_CLR
    } op_class_t;

    // execution sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_RUN
    } exec_state_t;

    // write port toward the file-register memory
    typedef struct packed {
        logic en;
        logic [6:0] addr;
        logic [7:0] data;
    } file_wr_t;

endpackage

// ### core/clear_phase_gen.sv
// four-phase instruction cycle generator
`timescale 1ns/1ps

module clear_phase_gen #(
    parameter int PHASE_CYC = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic [1:0] phase,
    output logic phase_stb
);

    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic [1:0] phase_ff;
    logic [1:0] nxt_phase;
    logic stb_ff;
    logic nxt_stb;

    // --------------------------------------------------------
    // divider: one strobe each time a new phase begins
    // --------------------------------------------------------
    always_comb
    begin
        nxt_cnt = cnt_ff + 16'h0001;
        nxt_phase = phase_ff;
        nxt_stb = 1'b0;
        if (cnt_ff == 16'(PHASE_CYC - 1))
        begin
            nxt_cnt = 16'h0000;
            nxt_phase = phase_ff + 2'h1;
            nxt_stb = 1'b1;
        end
    end

    // register divider state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_ff <= 16'h0000;
            phase_ff <= 2'h0;
            stb_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            phase_ff <= nxt_phase;
            stb_ff <= nxt_stb;
        end
    end

    assign phase = phase_ff;
    assign phase_stb = stb_ff;

endmodule

// ### core/clear_instruction_execute.sv
// decode and execute of the three clear-type instructions, apb slave
`timescale 1ns/1ps
`include "clear_exec_regs.svh"

// Summary of operation
// [RQ1] A register-clear opcode writes zero into the file register named by its seven-bit address field.
// [RQ2] A register-clear sets the zero flag to one and touches no other flag.
// [RQ3] An accumulator-clear loads zero into the accumulator and sets the zero flag, ignoring the low seven bits.
// [RQ4] The fixed watchdog-clear opcode zeroes watchdog counter and prescaler and sets time-out and power-down flags to one.
// [RQ5] Each clear is one word and one instruction cycle, its effect landing in the fourth phase.
module clear_instruction_execute #(
    parameter int PHASE_CYC = `CX_PHASE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output clear_exec_pkg::file_wr_t file_wr,
    output logic [7:0] accumulator,
    output logic zero_flag,
    output logic timeout_flag_n,
    output logic powerdown_flag_n,
    output logic watchdog_clear
);

    // --------------------------------------------------------
    // decode of an opcode into its class
    // --------------------------------------------------------
    function automatic clear_exec_pkg::op_class_t classify(
        input logic [13:0] op
    );
        classify = clear_exec_pkg::OP_OTHER;
        if (op == `CX_OPC_WDT_CLR)
            classify = clear_exec_pkg::OP_WDT_CLR; // see [RQ4]
        else if (op[13:7] == `CX_PFX_FILE_CLR)
            classify = clear_exec_pkg::OP_FILE_CLR; // see [RQ1]
        else if (op[13:7] == `CX_PFX_ACC_CLR)
            classify = clear_exec_pkg::OP_ACC_CLR; // see [RQ3]
    endfunction

    logic [1:0] phase;
    logic phase_stb;

    // instruction cycle phase source
    clear_phase_gen #(
        .PHASE_CYC(PHASE_CYC)
    ) u_phase (
        .pclk(pclk),
        .presetn(presetn),
        .phase(phase),
        .phase_stb(phase_stb)
    );

    // --------------------------------------------------------
    // apb access decode
    // --------------------------------------------------------
    logic acc_done;
    logic wr_done;
    logic hit_instr;
    logic hit_status;
    logic hit_acc;
    logic hit_count;
    logic mapped;
    logic pready_ff, nxt_pready;

    assign acc_done = psel & penable & pready_ff;
    assign wr_done = acc_done & pwrite;
    assign hit_instr = paddr == `CX_OFS_INSTR;
    assign hit_status = paddr == `CX_OFS_STATUS;
    assign hit_acc = paddr == `CX_OFS_ACC;
    assign hit_count = paddr == `CX_OFS_COUNT;
    assign mapped = hit_instr | hit_status | hit_acc | hit_count;

    // --------------------------------------------------------
    // state
    // --------------------------------------------------------
    clear_exec_pkg::exec_state_t state_ff, nxt_state;
    logic [13:0] instr_ff, nxt_instr;
    logic [7:0] acc_ff, nxt_acc;
    logic zero_ff, nxt_zero;
    logic to_n_ff, nxt_to_n;
    logic pd_n_ff, nxt_pd_n;
    logic wdt_clr_ff, nxt_wdt_clr;
    clear_exec_pkg::file_wr_t fwr_ff, nxt_fwr;
    logic [15:0] count_ff, nxt_count;
    logic pslverr_ff, nxt_pslverr;
    logic [31:0] prdata_ff, nxt_prdata;
    clear_exec_pkg::op_class_t cls;
    logic at_q1;
    logic at_q4;

    assign cls = classify(instr_ff);
    // phase counter has just wrapped into phase 0 or reached phase 3
    assign at_q1 = phase_stb & (phase == 2'h0);
    assign at_q4 = phase_stb & (phase == 2'h3);

    // --------------------------------------------------------
    // sequencer and execution effects
    // --------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        nxt_instr = instr_ff;
        nxt_acc = acc_ff;
        nxt_zero = zero_ff;
        nxt_to_n = to_n_ff;
        nxt_pd_n = pd_n_ff;
        nxt_wdt_clr = 1'b0;
        nxt_fwr = '0;
        nxt_count = count_ff;
        // software writes first, hardware effects below override them
        if (wr_done && hit_acc)
            nxt_acc = pwdata[7:0];
        if (wr_done && hit_status)
        begin
            nxt_zero = pwdata[`CX_ST_ZERO];
            nxt_to_n = pwdata[`CX_ST_TO];
            nxt_pd_n = pwdata[`CX_ST_PD];
        end
        case (state_ff)
            clear_exec_pkg::ST_IDLE:
            begin
                // a new opcode is only taken while idle
                if (wr_done && hit_instr)
                begin
                    nxt_instr = pwdata[13:0];
                    nxt_state = clear_exec_pkg::ST_ARMED;
                end
            end
            clear_exec_pkg::ST_ARMED:
            begin
                // wait for the start of an instruction cycle
                if (at_q1)
                    nxt_state = clear_exec_pkg::ST_RUN; // see [RQ5]
            end
            clear_exec_pkg::ST_RUN:
            begin
                if (at_q4) // see [RQ5]
                begin
                    nxt_state = clear_exec_pkg::ST_IDLE;
                    nxt_count = count_ff + 16'h0001;
                    case (cls)
                        clear_exec_pkg::OP_FILE_CLR:
                        begin
                            nxt_fwr.en = 1'b1; // see [RQ1]
                            nxt_fwr.addr = instr_ff[6:0]; // see [RQ1]
                            nxt_fwr.data = `CX_CLEAR_VALUE; // see [RQ1]
                            nxt_zero = 1'b1; // see [RQ2]
                        end
                        clear_exec_pkg::OP_ACC_CLR:
                        begin
                            nxt_acc = `CX_CLEAR_VALUE; // see [RQ3]
                            nxt_zero = 1'b1; // see [RQ3]
                        end
                        clear_exec_pkg::OP_WDT_CLR:
                        begin
                            nxt_wdt_clr = 1'b1; // see [RQ4]
                            nxt_to_n = 1'b1; // see [RQ4]
                            nxt_pd_n = 1'b1; // see [RQ4]
                        end
                        default:
                        begin
                            nxt_zero = nxt_zero; // other opcodes: no effect
                        end
                    endcase
                end
            end
            default:
            begin
                nxt_state = clear_exec_pkg::ST_IDLE;
            end
        endcase
    end

    // register sequencer and execution state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= clear_exec_pkg::ST_IDLE;
            instr_ff <= `CX_RST_INSTR;
            acc_ff <= `CX_RST_ACC;
            zero_ff <= `CX_RST_ZERO;
            to_n_ff <= `CX_RST_TO;
            pd_n_ff <= `CX_RST_PD;
            wdt_clr_ff <= 1'b0;
            fwr_ff <= '0;
            count_ff <= 16'h0000;
        end
        else
        begin
            state_ff <= nxt_state;
            instr_ff <= nxt_instr;
            acc_ff <= nxt_acc;
            zero_ff <= nxt_zero;
            to_n_ff <= nxt_to_n;
            pd_n_ff <= nxt_pd_n;
            wdt_clr_ff <= nxt_wdt_clr;
            fwr_ff <= nxt_fwr;
            count_ff <= nxt_count;
        end
    end

    // --------------------------------------------------------
    // apb answer: one wait state, read data and error
    // --------------------------------------------------------
    always_comb
    begin
        nxt_pready = psel & penable & ~pready_ff;
        nxt_pslverr = psel & penable & ~pready_ff & ~mapped;
        nxt_prdata = 32'h00000000;
        if (psel && penable && !pready_ff && !pwrite)
        begin
            if (hit_instr)
                nxt_prdata[13:0] = instr_ff;
            if (hit_status)
            begin
                nxt_prdata[`CX_ST_ZERO] = zero_ff;
                nxt_prdata[`CX_ST_PD] = pd_n_ff;
                nxt_prdata[`CX_ST_TO] = to_n_ff;
                nxt_prdata[`CX_ST_BUSY] =
                    state_ff != clear_exec_pkg::ST_IDLE;
                nxt_prdata[`CX_ST_CLASS_LO +: 2] = cls;
            end
            if (hit_acc)
                nxt_prdata[7:0] = acc_ff;
            if (hit_count)
                nxt_prdata[15:0] = count_ff;
        end
    end

    // register bus answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end
        else
        begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    end

    // --------------------------------------------------------
    // outputs, all straight from flip-flops
    // --------------------------------------------------------
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign file_wr = fwr_ff;
    assign accumulator = acc_ff;
    assign zero_flag = zero_ff;
    assign timeout_flag_n = to_n_ff;
    assign powerdown_flag_n = pd_n_ff;
    assign watchdog_clear = wdt_clr_ff;

endmodule

// ### tb/clear_instruction_execute_props.sv
// port assertions for the clear-instruction execute block
`timescale 1ns/1ps

module clear_instruction_execute_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire clear_exec_pkg::file_wr_t file_wr,
    input wire logic [7:0] accumulator,
    input wire logic zero_flag,
    input wire logic timeout_flag_n,
    input wire logic powerdown_flag_n,
    input wire logic watchdog_clear
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // --------------------------------------------------------------
    // bus handshake
    // --------------------------------------------------------------
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_first_access;
        psel && penable && !pready;
    endsequence

    a_one_wait: assert property (s_setup ##1 s_first_access |=> pready)
        else $error("access phase did not end after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");

    // --------------------------------------------------------------
    // clear effects
    // --------------------------------------------------------------
    a_file_data: assert property (
        file_wr.en |-> file_wr.data == 8'h00)
        else $error("file clear wrote a nonzero value");
    a_file_zero: assert property (
        file_wr.en |-> zero_flag)
        else $error("zero flag not set by file clear");
    a_file_pulse: assert property (
        file_wr.en |=> !file_wr.en)
        else $error("file write strobe longer than one cycle");
    a_wdt_flags: assert property (
        watchdog_clear |-> timeout_flag_n && powerdown_flag_n)
        else $error("time-out or power-down flag not set");
    a_wdt_pulse: assert property (
        watchdog_clear |=> !watchdog_clear)
        else $error("watchdog clear longer than one cycle");
    a_one_effect: assert property (
        !(file_wr.en && watchdog_clear))
        else $error("two clear effects in one cycle");
endmodule

// ### tb/clear_instruction_execute_tb.sv
// self-checking bench for the clear-instruction execute block
`timescale 1ns/1ps
`include "clear_exec_regs.svh"

module clear_instruction_execute_tb;
    localparam int PC = 2;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    clear_exec_pkg::file_wr_t file_wr;
    clear_exec_pkg::file_wr_t fw_last;
    logic [7:0] accumulator;
    logic zero_flag;
    logic timeout_flag_n;
    logic powerdown_flag_n;
    logic watchdog_clear;
    logic [31:0] rd;
    logic slv;
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;
    int t_go = 0;
    int t_cmt = 0;
    int t_fw = 0;
    int fw_cnt = 0;
    int wd_cnt = 0;

    clear_instruction_execute #(.PHASE_CYC(PC)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .file_wr(file_wr),
        .accumulator(accumulator), .zero_flag(zero_flag),
        .timeout_flag_n(timeout_flag_n),
        .powerdown_flag_n(powerdown_flag_n),
        .watchdog_clear(watchdog_clear)
    );

    // 100 MHz clock
    always #5 pclk = ~pclk;

    // pulse monitor and hang guard
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (file_wr.en === 1'b1)
        begin
            fw_cnt <= fw_cnt + 1;
            fw_last <= file_wr;
            t_fw <= cycles;
        end
        if (watchdog_clear === 1'b1)
            wd_cnt <= wd_cnt + 1;
        if (cycles == 20000)
        begin
            err_total++;
            end_of_test();
        end
    end

    // --------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the answer; if pready never comes only the hang guard ends this wait
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        t_go = cycles;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // issue one opcode and poll until it has retired
    task run(input logic [13:0] op);
        apb(1'b1, `CX_OFS_INSTR, {18'h0, op});
        t_cmt = t_go;
        rd = 32'h100;
        for (int n = 0; n < 40 && rd[8] !== 1'b0; n++)
            apb(1'b0, `CX_OFS_STATUS, 32'h0);
        chk({31'h0, rd[8]}, 32'h0);
    endtask

    task prep(input logic [31:0] st, input logic [7:0] acc);
        apb(1'b1, `CX_OFS_STATUS, st);
        apb(1'b1, `CX_OFS_ACC, {24'h0, acc});
    endtask

    // status: class, busy, time-out, power-down, zero
    task stat(input logic [31:0] exp);
        apb(1'b0, `CX_OFS_STATUS, 32'h0);
        chk(rd & 32'h3119, exp);
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task t_reset;
        stat(32'h0018);
        apb(1'b0, 12'hFF0, 32'h0);
        chk({31'h0, slv}, 32'h1);
        chk(rd, 32'h0);
    endtask

    task t_file(input logic [6:0] f);
        int n0;
        n0 = fw_cnt;
        prep(32'h0, 8'h5A);
        run({7'h03, f});
        chk(32'(fw_cnt - n0), 32'h1);
        chk({16'h0, fw_last}, {16'h0, 1'b1, f, 8'h00});
        stat(32'h1001);
        chk({31'h0, zero_flag}, 32'h1);
        apb(1'b0, `CX_OFS_ACC, 32'h0);
        chk(rd, 32'h5A);
        // effect lands three phases after the first phase-0 start
        chk(32'(t_fw - t_cmt >= 3 * PC + 2 && t_fw - t_cmt <= 7 * PC + 1),
            32'h1);
    endtask

    task t_acc(input logic [13:0] op);
        int n0;
        n0 = fw_cnt + wd_cnt;
        prep(32'h0, 8'h5A);
        run(op);
        stat(32'h2001);
        apb(1'b0, `CX_OFS_ACC, 32'h0);
        chk(rd, 32'h0);
        chk({24'h0, accumulator}, 32'h0);
        chk(32'(fw_cnt + wd_cnt - n0), 32'h0);
    endtask

    task t_wdt;
        int n0;
        n0 = wd_cnt;
        prep(32'h0, 8'h33);
        run(14'h0064);
        chk(32'(wd_cnt - n0), 32'h1);
        stat(32'h3018);
        chk({30'h0, timeout_flag_n, powerdown_flag_n}, 32'h3);
    endtask

    // non-clear opcodes retire with no effect
    task t_other(input logic [13:0] op);
        int n0;
        logic [31:0] c0;
        apb(1'b0, `CX_OFS_COUNT, 32'h0);
        c0 = rd;
        n0 = fw_cnt + wd_cnt;
        prep(32'h1, 8'h5A);
        run(op);
        stat(32'h0001);
        apb(1'b0, `CX_OFS_COUNT, 32'h0);
        chk(rd, c0 + 32'h1);
        chk(32'(fw_cnt + wd_cnt - n0), 32'h0);
    endtask

    task end_of_test;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_file(7'h45);
        t_file(7'h7F);
        t_file(7'h00);
        t_acc(14'h017F);
        t_acc(14'h0100);
        t_wdt();
        t_other(14'h0065);
        t_other(14'h0080);
        end_of_test();
    end
endmodule

bind clear_instruction_execute clear_instruction_execute_props props_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .file_wr(file_wr),
    .accumulator(accumulator), .zero_flag(zero_flag),
    .timeout_flag_n(timeout_flag_n), .powerdown_flag_n(powerdown_flag_n),
    .watchdog_clear(watchdog_clear)
);
